//--- logic/standby_defines.vh
`ifndef STANDBY_DEFINES_VH
`define STANDBY_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_CLK_CTRL    8'h00
`define OFF_MODE_REQ    8'h04
`define OFF_WAKE_CFG    8'h08
`define OFF_STATUS      8'h0c
`define OFF_WAKE_CAUSE  8'h10
`define OFF_IRQ_LEVEL   8'h14
`define OFF_IRQ_GRANT   8'h18

// ----------------------------------------------------------------
// Clock control fields
// ----------------------------------------------------------------
`define CC_SEL_LSB      0
`define CC_SEL_MSB      1
`define CC_RC_EN        2
`define CC_CF_EN        3
`define CC_XT_EN        4
`define CC_PLL_EN       5
`define CC_WIDTH        6
`define CLK_CTRL_RESET  6'h04
`define SRC_RC          2'h0
`define SRC_CF          2'h1
`define SRC_XT          2'h2

// ----------------------------------------------------------------
// Mode request codes
// ----------------------------------------------------------------
`define MODE_NONE       2'h0
`define MODE_HALT       2'h1
`define MODE_HOLD       2'h2
`define MODE_XHOLD      2'h3

// ----------------------------------------------------------------
// Wake configuration fields
// ----------------------------------------------------------------
`define WC_EN_LSB       0
`define WC_EN_MSB       4
`define WC_LVL_LSB      8
`define WC_LVL_MSB      12
`define WAKE_CFG_RESET  5'h00

// ----------------------------------------------------------------
// Wake cause bits
// ----------------------------------------------------------------
`define WK_RESET        0
`define WK_EXT          1
`define WK_PORT0        2
`define WK_USB          3
`define WK_BTMR         4
`define WK_IR           5
`define WK_IRQ          6
`define WK_WIDTH        7

// ----------------------------------------------------------------
// Interrupt priority levels
// ----------------------------------------------------------------
`define LVL_NONE        2'h0
`define LVL_LOW         2'h1
`define LVL_HIGH        2'h2
`define LVL_TOP         2'h3
`define IRQ_LEVEL_RESET 10'h000

`endif

//--- logic/standby_mode_controller.v
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "standby_defines.vh"

module standby_mode_controller #(
  parameter ADDR_W = 8,
  parameter NVEC   = 10
) (
  input  wire              clk,
  input  wire              reset,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata_r,
  output reg               pready_r,
  output reg               pslverr_r,
  input  wire              external_reset_pin_n,
  input  wire              ext_irq_pin_zero,
  input  wire              ext_irq_pin_one,
  input  wire              ext_irq_pin_two,
  input  wire              ext_irq_pin_four,
  input  wire              ext_irq_pin_five,
  input  wire              pll_lock,
  input  wire              rc_osc_ready,
  input  wire              cf_osc_ready,
  input  wire              xt_osc_ready,
  input  wire              port0_irq,
  input  wire              usb_bus_active_irq,
  input  wire              base_timer_irq,
  input  wire              ir_rx_irq,
  input  wire [NVEC-1:0]   irq_req,
  input  wire [1:0]        core_service_level,
  output reg               cpu_run_r,
  output reg               periph_clk_en_r,
  output reg               ir_rx_clk_en_r,
  output reg               rc_osc_en_r,
  output reg               cf_osc_en_r,
  output reg               xt_osc_en_r,
  output reg               pll_en_r,
  output reg               usb_clk_en_r,
  output reg               tod_clk_en_r,
  output reg  [1:0]        sys_clk_sel_r,
  output reg               sys_reset_req_r,
  output reg  [2:0]        mode_state_r,
  output reg               grant_valid_r,
  output reg  [3:0]        grant_vec_r,
  output reg  [1:0]        grant_level_r
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] ST_RUN   = 3'h0;
  localparam [2:0] ST_HALT  = 3'h1;
  localparam [2:0] ST_HOLD  = 3'h2;
  localparam [2:0] ST_XHOLD = 3'h3;
  localparam [2:0] ST_WAKE  = 3'h4;

  localparam        NPINS    = 10;
  localparam [9:0]  PIN_IDLE = 10'h001;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [NPINS-1:0] pins_raw;
  wire [NPINS-1:0] pins_f;

  assign pins_raw = {xt_osc_ready, cf_osc_ready, rc_osc_ready, pll_lock,
                     ext_irq_pin_five, ext_irq_pin_four, ext_irq_pin_two,
                     ext_irq_pin_one, ext_irq_pin_zero, external_reset_pin_n};

  genvar g;
  generate
    for (g = 0; g < NPINS; g = g + 1) begin : sync
      reg s1;
      reg s2;
      reg s3;
      reg f;
      // A level counts only once stages two and three agree
      always @(posedge clk) begin
        if (reset) begin
          s1 <= PIN_IDLE[g];
          s2 <= PIN_IDLE[g];
          s3 <= PIN_IDLE[g];
          f  <= PIN_IDLE[g];
        end else begin
          s1 <= pins_raw[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            f <= s3;
          end
        end
      end
      assign pins_f[g] = f;
    end
  endgenerate

  wire       rst_low  = ~pins_f[0];
  wire [4:0] ext_pins = pins_f[5:1];
  wire       lock_s   = pins_f[6];
  wire       rc_rdy   = pins_f[7];
  wire       cf_rdy   = pins_f[8];
  wire       xt_rdy   = pins_f[9];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [`CC_WIDTH-1:0] clk_ctrl_r;
  reg  [4:0]           ext_en_r;
  reg  [4:0]           ext_lvl_r;
  reg  [`WK_WIDTH-1:0] cause_r;
  reg  [NVEC-1:0]      irq_level_r;
  reg  [2:0]           state_r;
  reg  [2:0]           state_nxt;
  reg  [`WK_WIDTH-1:0] cause_set;
  reg  [3:0]           need_r;

  wire acc     = psel & penable;
  wire done    = acc & pready_r;
  wire wr_done = done & pwrite;

  // ----------------------------------------------------------------
  // Wake conditions
  // ----------------------------------------------------------------
  wire ext_hit    = |(ext_en_r & ~(ext_pins ^ ext_lvl_r));
  wire hold_wake  = rst_low | ext_hit | port0_irq | usb_bus_active_irq;
  wire xhold_wake = hold_wake | base_timer_irq | ir_rx_irq;
  wire halt_wake  = rst_low | (|irq_req);

  wire want_rc  = clk_ctrl_r[`CC_RC_EN];
  wire want_cf  = clk_ctrl_r[`CC_CF_EN];
  wire want_xt  = clk_ctrl_r[`CC_XT_EN];
  wire want_pll = clk_ctrl_r[`CC_PLL_EN];
  wire clocks_ok = (~want_rc | rc_rdy) & (~want_cf | cf_rdy) &
                   (~want_xt | xt_rdy) & (~want_pll | lock_s) & ~(|need_r);

  wire       mode_wr   = wr_done & (paddr == `OFF_MODE_REQ);
  wire [1:0] mode_code = pwdata[1:0];

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    cause_set = {`WK_WIDTH{1'b0}};
    case (state_r)
      ST_RUN: begin
        // Requests are only taken while the core is executing
        if (mode_wr) begin
          case (mode_code)
            `MODE_HALT:  state_nxt = ST_HALT;
            `MODE_HOLD:  state_nxt = ST_HOLD;
            `MODE_XHOLD: state_nxt = ST_XHOLD;
            default:     state_nxt = ST_RUN;
          endcase
        end
      end
      ST_HALT: begin
        if (halt_wake) begin
          state_nxt = ST_RUN;
          cause_set[`WK_RESET] = rst_low;
          cause_set[`WK_IRQ]   = |irq_req;
        end
      end
      ST_HOLD: begin
        if (hold_wake) begin
          state_nxt = ST_WAKE;
          cause_set[`WK_RESET] = rst_low;
          cause_set[`WK_EXT]   = ext_hit;
          cause_set[`WK_PORT0] = port0_irq;
          cause_set[`WK_USB]   = usb_bus_active_irq;
        end
      end
      ST_XHOLD: begin
        if (xhold_wake) begin
          state_nxt = ST_WAKE;
          cause_set[`WK_RESET] = rst_low;
          cause_set[`WK_EXT]   = ext_hit;
          cause_set[`WK_PORT0] = port0_irq;
          cause_set[`WK_USB]   = usb_bus_active_irq;
          cause_set[`WK_BTMR]  = base_timer_irq;
          cause_set[`WK_IR]    = ir_rx_irq;
        end
      end
      ST_WAKE: begin
        if (clocks_ok) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Clock gating outputs
  // ----------------------------------------------------------------
  // Derived from the next state so that every gate is a flip-flop
  // and still switches on the same edge as the state itself
  wire n_run   = (state_nxt == ST_RUN);
  wire n_halt  = (state_nxt == ST_HALT);
  wire n_hold  = (state_nxt == ST_HOLD);
  wire n_xhold = (state_nxt == ST_XHOLD);
  wire n_sleep = n_hold | n_xhold;

  // A stopped oscillator still shows a stale ready through its synchroniser
  // for a few cycles; a short sleep must not trust it, so wait for it to drop
  wire enter_sleep = n_sleep & (state_r != ST_HOLD) & (state_r != ST_XHOLD);
  wire enter_hold  = n_hold & (state_r != ST_HOLD);

  always @(posedge clk) begin
    if (reset) begin
      need_r <= 4'h0;
    end else begin
      need_r <= {want_xt & enter_hold, want_pll & enter_sleep, want_cf & enter_sleep, want_rc & enter_sleep} |
                (need_r & {xt_rdy, lock_s, cf_rdy, rc_rdy});
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      cpu_run_r       <= 1'b0;
      periph_clk_en_r <= 1'b0;
      ir_rx_clk_en_r  <= 1'b0;
      rc_osc_en_r     <= 1'b0;
      cf_osc_en_r     <= 1'b0;
      xt_osc_en_r     <= 1'b0;
      pll_en_r        <= 1'b0;
      usb_clk_en_r    <= 1'b0;
      tod_clk_en_r    <= 1'b0;
      sys_clk_sel_r   <= `SRC_RC;
      sys_reset_req_r <= 1'b0;
      mode_state_r    <= ST_RUN;
    end else begin
      cpu_run_r       <= n_run;
      periph_clk_en_r <= n_run | n_halt;
      ir_rx_clk_en_r  <= n_run | n_halt | n_xhold;
      // Halt leaves the oscillators on software's settings
      rc_osc_en_r     <= want_rc & ~n_sleep;
      cf_osc_en_r     <= want_cf & ~n_sleep;
      pll_en_r        <= want_pll & ~n_sleep;
      xt_osc_en_r     <= want_xt & ~n_hold;
      usb_clk_en_r    <= want_pll & ~n_sleep & lock_s;
      tod_clk_en_r    <= want_xt & ~n_hold & xt_rdy;
      sys_clk_sel_r   <= clk_ctrl_r[`CC_SEL_MSB:`CC_SEL_LSB];
      sys_reset_req_r <= rst_low;
      mode_state_r    <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt priority arbiter
  // ----------------------------------------------------------------
  reg [1:0] best_lvl;
  reg [3:0] best_vec;
  reg [1:0] lvl_i;
  integer   i;

  always @* begin
    best_lvl = `LVL_NONE;
    best_vec = 4'h0;
    lvl_i    = `LVL_NONE;
    // Scan downward with >= so the lowest vector wins a tie
    for (i = NVEC - 1; i >= 0; i = i - 1) begin
      if (irq_level_r[i]) begin
        lvl_i = (i < 2) ? `LVL_TOP : `LVL_HIGH;
      end else begin
        lvl_i = `LVL_LOW;
      end
      if (irq_req[i] && (lvl_i >= best_lvl)) begin
        best_lvl = lvl_i;
        best_vec = i[3:0];
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      grant_valid_r <= 1'b0;
      grant_vec_r   <= 4'h0;
      grant_level_r <= `LVL_NONE;
    end else begin
      grant_valid_r <= (best_lvl > core_service_level);
      grant_vec_r   <= best_vec;
      grant_level_r <= best_lvl;
    end
  end

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  reg [31:0] rd_mux;
  reg        addr_hit;

  always @* begin
    rd_mux   = 32'h0000_0000;
    addr_hit = 1'b1;
    if (paddr == `OFF_CLK_CTRL) begin
      rd_mux[`CC_WIDTH-1:0] = clk_ctrl_r;
    end else if (paddr == `OFF_MODE_REQ) begin
      rd_mux[2:0] = state_r;
    end else if (paddr == `OFF_WAKE_CFG) begin
      rd_mux[`WC_EN_MSB:`WC_EN_LSB]   = ext_en_r;
      rd_mux[`WC_LVL_MSB:`WC_LVL_LSB] = ext_lvl_r;
    end else if (paddr == `OFF_STATUS) begin
      rd_mux = {19'h00000, ext_pins, xt_rdy, cf_rdy, rc_rdy, lock_s,
                rst_low, state_r};
    end else if (paddr == `OFF_WAKE_CAUSE) begin
      rd_mux[`WK_WIDTH-1:0] = cause_r;
    end else if (paddr == `OFF_IRQ_LEVEL) begin
      rd_mux[NVEC-1:0] = irq_level_r;
    end else if (paddr == `OFF_IRQ_GRANT) begin
      rd_mux[6:0] = {grant_valid_r, grant_level_r, grant_vec_r};
    end else begin
      addr_hit = 1'b0;
    end
  end

  // One wait state: data and error are settled with pready
  always @(posedge clk) begin
    if (reset) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= acc & ~pready_r;
      pslverr_r <= acc & ~pready_r & ~addr_hit;
      if (acc & ~pready_r & ~pwrite) begin
        prdata_r <= rd_mux;
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      clk_ctrl_r  <= `CLK_CTRL_RESET;
      ext_en_r    <= `WAKE_CFG_RESET;
      ext_lvl_r   <= `WAKE_CFG_RESET;
      irq_level_r <= `IRQ_LEVEL_RESET;
    end else if (wr_done) begin
      if (paddr == `OFF_CLK_CTRL) begin
        clk_ctrl_r <= pwdata[`CC_WIDTH-1:0];
      end else if (paddr == `OFF_WAKE_CFG) begin
        ext_en_r  <= pwdata[`WC_EN_MSB:`WC_EN_LSB];
        ext_lvl_r <= pwdata[`WC_LVL_MSB:`WC_LVL_LSB];
      end else if (paddr == `OFF_IRQ_LEVEL) begin
        irq_level_r <= pwdata[NVEC-1:0];
      end
    end
  end

  // Write one to clear; a wake in the same cycle keeps its bit
  wire [`WK_WIDTH-1:0] cause_clr = (wr_done && (paddr == `OFF_WAKE_CAUSE)) ?
                                   pwdata[`WK_WIDTH-1:0] : {`WK_WIDTH{1'b0}};

  always @(posedge clk) begin
    if (reset) begin
      cause_r <= {`WK_WIDTH{1'b0}};
    end else begin
      cause_r <= (cause_r & ~cause_clr) | cause_set;
    end
  end

endmodule

`default_nettype wire

//--- sim/sbm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sbm_monitor #(
  parameter NVEC = 10
) (
  input wire logic            clk,
  input wire logic            reset,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pready_r,
  input wire logic            port0_irq,
  input wire logic            base_timer_irq,
  input wire logic [NVEC-1:0] irq_req,
  input wire logic            cpu_run_r,
  input wire logic            periph_clk_en_r,
  input wire logic            ir_rx_clk_en_r,
  input wire logic            rc_osc_en_r,
  input wire logic            cf_osc_en_r,
  input wire logic            xt_osc_en_r,
  input wire logic            pll_en_r,
  input wire logic [2:0]      mode_state_r,
  input wire logic            grant_valid_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Steps of a bus access
  // ----------------------------------------
  sequence setup_s; psel && !penable; endsequence
  sequence one_wait_s; !pready_r ##1 pready_r; endsequence
  wire fast_off = !rc_osc_en_r && !cf_osc_en_r && !pll_en_r && !periph_clk_en_r && !cpu_run_r;
  wire [3:0] oscs = {rc_osc_en_r, cf_osc_en_r, xt_osc_en_r, pll_en_r};

  chk_apb_one_wait: assert property (setup_s |=> one_wait_s) else $error("bus answer late");
  chk_run_exec: assert property (!$past(reset) && mode_state_r == 3'h0 |-> cpu_run_r) else $error("core stopped in run");
  chk_halt_periph: assert property (mode_state_r == 3'h1 |-> !cpu_run_r && periph_clk_en_r)
    else $error("halt gating wrong");
  chk_halt_osc_kept: assert property (mode_state_r == 3'h1 && $past(mode_state_r) == 3'h0 |-> $stable(oscs))
    else $error("halt touched an oscillator");
  chk_hold_all_stop: assert property (mode_state_r == 3'h2 |-> fast_off && !xt_osc_en_r && !ir_rx_clk_en_r)
    else $error("hold left a clock on");
  chk_xhold_ir_kept: assert property (mode_state_r == 3'h3 |-> fast_off && ir_rx_clk_en_r)
    else $error("crystal hold gating wrong");
  chk_xhold_xt_kept: assert property (mode_state_r == 3'h3 && $past(mode_state_r) != 3'h3 |-> $stable(xt_osc_en_r))
    else $error("crystal state changed on entry");
  chk_halt_irq_wake: assert property (mode_state_r == 3'h1 && |irq_req |-> ##[1:2] mode_state_r == 3'h0)
    else $error("halt not ended");
  chk_hold_port_wake: assert property (mode_state_r == 3'h2 && port0_irq |=> mode_state_r inside {3'h4, 3'h0})
    else $error("hold not ended by port");
  chk_xhold_timer_wake: assert property (mode_state_r == 3'h3 && base_timer_irq |=> mode_state_r != 3'h3)
    else $error("crystal hold not ended by timer");
  chk_grant_quiet: assert property ($past(irq_req) == '0 |-> !grant_valid_r) else $error("grant with no request");
endmodule
`default_nettype wire

//--- sim/osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Oscillators need a few cycles to settle after enable and fail at once on stop
module osc_model (
  input wire logic  clk,
  input wire logic  rc_osc_en_r,
  input wire logic  cf_osc_en_r,
  input wire logic  xt_osc_en_r,
  input wire logic  pll_en_r,
  output var logic  rc_osc_ready,
  output var logic  cf_osc_ready,
  output var logic  xt_osc_ready,
  output var logic  pll_lock
);
  logic [3:0] en, d1, d2, d3;
  assign en = {pll_en_r, xt_osc_en_r, cf_osc_en_r, rc_osc_en_r};
  always @(posedge clk) begin
    d1 <= en;
    d2 <= d1;
    d3 <= d2;
  end
  assign {pll_lock, xt_osc_ready, cf_osc_ready, rc_osc_ready} = en & d1 & d2 & d3;
endmodule
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "standby_defines.vh"
module testbench;
  logic        clk, reset, psel, penable, pwrite, rst_pin_n, port0, usb, btmr, ir;
  logic [7:0]  paddr, lfsr;
  logic [31:0] pwdata;
  logic [4:0]  ext;
  logic [9:0]  irq_req, lvl;
  logic [1:0]  csl;
  logic [32:0] exp_q[$];
  wire [31:0]  prdata_r;
  wire         pready_r, pslverr_r, pll_lock, rc_rdy, cf_rdy, xt_rdy, cpu_run, periph, ir_en;
  wire         rc_en, cf_en, xt_en, pll_en, rst_req, gv, usb_en, tod_en;
  wire [1:0]   sel, gl;
  wire [2:0]   st;
  wire [3:0]   gvec;
  int          err_count, n_tests, cyc, m, s, i;

  standby_mode_controller u_standby_mode_controller (.clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata_r, .pready_r, .pslverr_r, .external_reset_pin_n(rst_pin_n),
    .ext_irq_pin_zero(ext[0]), .ext_irq_pin_one(ext[1]), .ext_irq_pin_two(ext[2]),
    .ext_irq_pin_four(ext[3]), .ext_irq_pin_five(ext[4]), .pll_lock, .rc_osc_ready(rc_rdy),
    .cf_osc_ready(cf_rdy), .xt_osc_ready(xt_rdy), .port0_irq(port0), .usb_bus_active_irq(usb),
    .base_timer_irq(btmr), .ir_rx_irq(ir), .irq_req, .core_service_level(csl), .cpu_run_r(cpu_run),
    .periph_clk_en_r(periph), .ir_rx_clk_en_r(ir_en), .rc_osc_en_r(rc_en), .cf_osc_en_r(cf_en),
    .xt_osc_en_r(xt_en), .pll_en_r(pll_en), .usb_clk_en_r(usb_en), .tod_clk_en_r(tod_en), .sys_clk_sel_r(sel),
    .sys_reset_req_r(rst_req), .mode_state_r(st), .grant_valid_r(gv), .grant_vec_r(gvec),
    .grant_level_r(gl));
  osc_model u_osc_model (.clk, .rc_osc_en_r(rc_en), .cf_osc_en_r(cf_en), .xt_osc_en_r(xt_en),
    .pll_en_r(pll_en), .rc_osc_ready(rc_rdy), .cf_osc_ready(cf_rdy), .xt_osc_ready(xt_rdy), .pll_lock);

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // A spare edge first, so two transfers never assign psel in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready_r !== 1'b1 && k < 20);
    if (k >= 20) err_count++;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(0, a, 0);
  endtask
  task automatic wait_st(input logic [2:0] w);
    for (int k = 0; k < 60 && st !== w; k++) @(posedge clk);
    check(st, w);
  endtask
  task automatic drive_src(input int n);
    case (n)
      0: rst_pin_n <= 0;
      1: ext[3] <= 1;
      2: port0 <= 1;
      3: usb <= 1;
      4: btmr <= 1;
      default: ir <= 1;
    endcase
  endtask
  function automatic logic [6:0] arb(input logic [9:0] r, input logic [1:0] c);
    logic [1:0] bl, l;
    logic [3:0] bv;
    bl = 0;
    bv = 0;
    for (int k = 0; k < 10; k++) begin
      l = lvl[k] ? (k < 2 ? 2'h3 : 2'h2) : 2'h1;
      if (r[k] && l > bl) begin
        bl = l;
        bv = 4'(k);
      end
    end
    return {bl > c, bl, bv};
  endfunction

  // Read answers are matched against the oldest note
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready_r === 1'b1) begin
      if (exp_q.size() == 0) check(0, 1);
      else check({pslverr_r, prdata_r}, exp_q.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ext, port0, usb, btmr, ir, irq_req, csl} = '0;
    rst_pin_n = 1;
    reset = 1;
    lfsr = 8'h4c;
    lvl = 10'h005;
    repeat (10) @(posedge clk);
    reset <= 0;
    rd(`OFF_CLK_CTRL, 33'h4);
    rd(8'h40, 33'h1_0000_0000);
    apb(1, `OFF_CLK_CTRL, 32'h3e);
    apb(1, `OFF_WAKE_CFG, 32'h808);
    rd(`OFF_CLK_CTRL, 33'h3e);
    check(sel, `SRC_XT);
    apb(1, `OFF_MODE_REQ, 32'h1);
    wait_st(3'h1);
    check({cpu_run, periph, rc_en, cf_en, xt_en, pll_en}, 6'b011111);
    irq_req <= 10'h200;
    wait_st(3'h0);
    irq_req <= 0;
    for (m = 2; m < 4; m++) begin
      for (s = 0; s < 6; s++) begin
        apb(1, `OFF_MODE_REQ, m);
        wait_st(m[2:0]);
        check({periph, rc_en, cf_en, xt_en, pll_en, ir_en, usb_en, tod_en}, m == 2 ? 8'h0 : 8'h15);
        drive_src(s);
        if (m == 2 && s > 3) begin
          repeat (20) @(posedge clk);
          check(st, 3'h2);
          drive_src(2);
        end
        wait_st(3'h0);
        if (s == 0) check(rst_req, 1);
        check({cpu_run, rc_rdy, cf_rdy, xt_rdy, pll_lock, usb_en, tod_en}, 7'h7f);
        {rst_pin_n, ext, port0, usb, btmr, ir} <= 10'h200;
        repeat (8) @(posedge clk);
      end
    end
    rd(`OFF_WAKE_CAUSE, 33'h7f);
    apb(1, `OFF_WAKE_CAUSE, 32'h7f);
    rd(`OFF_WAKE_CAUSE, 33'h0);
    apb(1, `OFF_IRQ_LEVEL, {22'h0, lvl});
    for (i = 0; i < 40; i++) begin
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      irq_req <= {lfsr[7:6], lfsr};
      csl <= lfsr[2:1];
      @(posedge clk);
      @(posedge clk);
      check(gv ? {gv, gl, gvec} : 7'h0, arb({lfsr[7:6], lfsr}, lfsr[2:1]) & (arb({lfsr[7:6], lfsr}, lfsr[2:1]) >> 6 ? 7'h7f : 7'h0));
    end
    finish_test();
  end
endmodule

bind standby_mode_controller sbm_monitor #(.NVEC(NVEC)) u_sbm_monitor (.clk, .reset, .psel, .penable, .pready_r,
  .port0_irq, .base_timer_irq, .irq_req, .cpu_run_r, .periph_clk_en_r, .ir_rx_clk_en_r, .rc_osc_en_r,
  .cf_osc_en_r, .xt_osc_en_r, .pll_en_r, .mode_state_r, .grant_valid_r);
`default_nettype wire
